// ==== hw/spr_pin_route.v ====
`timescale 1ns/1ns
`include "spr_regs.vh"

module spr_pin_route (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    // timer control
    input  wire [7:0]  i_timer_remap_option,
    input  wire [3:0]  i_timer_output_enable,
    input  wire        i_gp_timer_channel_1_out,
    input  wire        i_gp_timer_channel_3_out,
    input  wire        i_gp_timer_channel_4_out,
    // port configuration
    input  wire [15:0] i_port_a_low_config,
    input  wire [15:0] i_port_b_low_config,
    input  wire [15:0] i_port_b_high_config,
    input  wire [3:0]  i_gpio_out,
    // serial controller 1
    input  wire [1:0]  i_serial1_mode_select,
    input  wire [7:0]  i_serial1_spi_config,
    input  wire [7:0]  i_serial1_uart_config,
    input  wire        i_serial1_spi_clock_out,
    input  wire        i_serial1_rts_n,
    // serial controller 2
    input  wire [1:0]  i_serial2_mode_select,
    input  wire [7:0]  i_serial2_spi_config,
    input  wire        i_serial2_master_out,
    input  wire        i_serial2_slave_out,
    input  wire        i_serial2_i2c_data_out,
    // pads, bit 0 port_a_pin_0, 1 port_a_pin_1, 2 port_b_pin_3, 3 port_b_pin_4
    input  wire [3:0]  i_pin_in,
    output wire [3:0]  o_pin_out,
    output wire [3:0]  o_pin_oe_n,
    // gpio input readback
    output reg  [3:0]  o_gpio_in,
    // timer inputs
    output reg         o_gp_timer_channel_1_in,
    output reg         o_gp_timer_channel_3_in,
    output reg         o_gp_timer_channel_4_in,
    // serial controller 1 inputs
    output reg         o_serial1_spi_clock_in,
    output reg         o_serial1_cts_n,
    output reg         o_serial1_slave_select_n,
    // serial controller 2 inputs
    output reg         o_serial2_slave_in,
    output reg         o_serial2_master_in,
    output reg         o_serial2_i2c_data_in
);

    // ****************************************************************
    // pin indices
    // ****************************************************************
    localparam integer PIN_A0 = 0;
    localparam integer PIN_A1 = 1;
    localparam integer PIN_B3 = 2;
    localparam integer PIN_B4 = 3;

    // ****************************************************************
    // decoded controls
    // ****************************************************************
    wire       remap1 = i_timer_remap_option[`SPR_REMAP_CH1_BIT];
    wire       remap3 = i_timer_remap_option[`SPR_REMAP_CH3_BIT];
    wire       remap4 = i_timer_remap_option[`SPR_REMAP_CH4_BIT];
    wire       toe1   = i_timer_output_enable[`SPR_TOE_CH1_BIT];
    wire       toe3   = i_timer_output_enable[`SPR_TOE_CH3_BIT];
    wire       toe4   = i_timer_output_enable[`SPR_TOE_CH4_BIT];

    wire       s1_spi    = (i_serial1_mode_select == `SPR_MODE_SPI);
    wire       s1_uart   = (i_serial1_mode_select == `SPR_MODE_UART);
    wire       s1_master = s1_spi & i_serial1_spi_config[`SPR_SPI_MASTER_BIT];
    wire       s1_slave  = s1_spi & ~i_serial1_spi_config[`SPR_SPI_MASTER_BIT];
    wire       s1_flow   = s1_uart & i_serial1_uart_config[`SPR_UART_FLOW_BIT];
    wire       s2_spi    = (i_serial2_mode_select == `SPR_MODE_SPI);
    wire       s2_i2c    = (i_serial2_mode_select == `SPR_MODE_I2C);
    wire       s2_master = s2_spi & i_serial2_spi_config[`SPR_SPI_MASTER_BIT];
    wire       s2_slave  = s2_spi & ~i_serial2_spi_config[`SPR_SPI_MASTER_BIT];

    // ****************************************************************
    // per-pin alternate source selection
    // ****************************************************************
    wire [3:0] tmr_sel;
    wire [3:0] tmr_data;
    wire [3:0] ser_sel;
    wire [3:0] ser_data;
    wire [15:0] field;

    assign tmr_sel[PIN_B3]  = remap3 & toe3;
    assign tmr_sel[PIN_A1]  = ~remap3 & toe3;
    assign tmr_sel[PIN_B4]  = remap4 & toe4;
    assign tmr_sel[PIN_A0]  = ~remap1 & toe1;

    assign tmr_data[PIN_B3] = i_gp_timer_channel_3_out;
    assign tmr_data[PIN_A1] = i_gp_timer_channel_3_out;
    assign tmr_data[PIN_B4] = i_gp_timer_channel_4_out;
    assign tmr_data[PIN_A0] = i_gp_timer_channel_1_out;

    assign ser_sel[PIN_B3]  = s1_master;
    assign ser_sel[PIN_B4]  = s1_flow;
    assign ser_sel[PIN_A0]  = s2_master;
    assign ser_sel[PIN_A1]  = s2_slave | s2_i2c;

    assign ser_data[PIN_B3] = i_serial1_spi_clock_out;
    assign ser_data[PIN_B4] = i_serial1_rts_n;
    assign ser_data[PIN_A0] = i_serial2_master_out;
    assign ser_data[PIN_A1] = s2_i2c ? i_serial2_i2c_data_out : i_serial2_slave_out;

    assign field[4*PIN_A0 +: 4] = i_port_a_low_config[`SPR_PAL_PIN0_HI:`SPR_PAL_PIN0_LO];
    assign field[4*PIN_A1 +: 4] = i_port_a_low_config[`SPR_PAL_PIN1_HI:`SPR_PAL_PIN1_LO];
    assign field[4*PIN_B3 +: 4] = i_port_b_low_config[`SPR_PBL_PIN3_HI:`SPR_PBL_PIN3_LO];
    assign field[4*PIN_B4 +: 4] = i_port_b_high_config[`SPR_PBH_PIN4_HI:`SPR_PBH_PIN4_LO];

    // ****************************************************************
    // pad drivers
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_pin
            spr_pin_cell u_cell (
                .i_clk         (i_clk),
                .i_srst        (i_srst),
                .i_field       (field[4*g +: 4]),
                .i_gpio_data   (i_gpio_out[g]),
                .i_timer_sel   (tmr_sel[g]),
                .i_timer_data  (tmr_data[g]),
                .i_serial_sel  (ser_sel[g]),
                .i_serial_data (ser_data[g]),
                .o_out         (o_pin_out[g]),
                .o_oe_n        (o_pin_oe_n[g])
            );
        end
    endgenerate

    // ****************************************************************
    // input routing
    // ****************************************************************
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_gpio_in                <= 4'h0;
            o_gp_timer_channel_1_in  <= `SPR_RST_IN_LOW;
            o_gp_timer_channel_3_in  <= `SPR_RST_IN_LOW;
            o_gp_timer_channel_4_in  <= `SPR_RST_IN_LOW;
            o_serial1_spi_clock_in   <= `SPR_RST_IN_LOW;
            o_serial1_cts_n          <= `SPR_RST_IN_LOW;
            o_serial1_slave_select_n <= `SPR_RST_IN_HIGH;
            o_serial2_slave_in       <= `SPR_RST_IN_LOW;
            o_serial2_master_in      <= `SPR_RST_IN_LOW;
            o_serial2_i2c_data_in    <= `SPR_RST_IN_HIGH;
        end else begin
            o_gpio_in                <= i_pin_in;
            o_gp_timer_channel_3_in  <= remap3 ? i_pin_in[PIN_B3] : i_pin_in[PIN_A1];
            o_gp_timer_channel_4_in  <= remap4 & i_pin_in[PIN_B4];
            o_gp_timer_channel_1_in  <= ~remap1 & i_pin_in[PIN_A0];
            o_serial1_spi_clock_in   <= s1_slave & i_pin_in[PIN_B3];
            o_serial1_cts_n          <= s1_flow & i_pin_in[PIN_B3];
            o_serial1_slave_select_n <= s1_slave ? i_pin_in[PIN_B4] : 1'b1;
            o_serial2_slave_in       <= s2_slave & i_pin_in[PIN_A0];
            o_serial2_master_in      <= s2_master & i_pin_in[PIN_A1];
            o_serial2_i2c_data_in    <= s2_i2c ? i_pin_in[PIN_A1] : 1'b1;
        end
    end

endmodule

// ==== hw/spr_regs.vh ====
`ifndef SPR_REGS_VH
`define SPR_REGS_VH

// ****************************************************************
// timer remap option bit positions
// ****************************************************************
`define SPR_REMAP_CH1_BIT      4
`define SPR_REMAP_CH3_BIT      6
`define SPR_REMAP_CH4_BIT      7

// ****************************************************************
// timer output enable bit positions (one per channel)
// ****************************************************************
`define SPR_TOE_CH1_BIT        0
`define SPR_TOE_CH3_BIT        2
`define SPR_TOE_CH4_BIT        3

// ****************************************************************
// port configuration field positions
// ****************************************************************
`define SPR_PBL_PIN3_HI        15
`define SPR_PBL_PIN3_LO        12
`define SPR_PBH_PIN4_HI        3
`define SPR_PBH_PIN4_LO        0
`define SPR_PAL_PIN0_HI        3
`define SPR_PAL_PIN0_LO        0
`define SPR_PAL_PIN1_HI        7
`define SPR_PAL_PIN1_LO        4

// ****************************************************************
// port configuration field codes
// ****************************************************************
`define SPR_CFG_GPIO_OUT       4'h1
`define SPR_CFG_GPIO_OD        4'h5
`define SPR_CFG_ALT_OUT        4'h9
`define SPR_CFG_ALT_OD         4'hD

// ****************************************************************
// serial controller mode codes and config bits
// ****************************************************************
`define SPR_MODE_OFF           2'h0
`define SPR_MODE_UART          2'h1
`define SPR_MODE_SPI           2'h2
`define SPR_MODE_I2C           2'h3
`define SPR_SPI_MASTER_BIT     4
`define SPR_UART_FLOW_BIT      5

// ****************************************************************
// reset values
// ****************************************************************
`define SPR_RST_PIN_OUT        1'h0
`define SPR_RST_PIN_OE_N       1'h1
`define SPR_RST_IN_LOW         1'h0
`define SPR_RST_IN_HIGH        1'h1

`endif

// ==== hw/spr_pin_cell.v ====
`timescale 1ns/1ns
`include "spr_regs.vh"

module spr_pin_cell (
    // clock and reset
    input  wire       i_clk,
    input  wire       i_srst,
    // pin configuration
    input  wire [3:0] i_field,
    input  wire       i_gpio_data,
    // alternate sources
    input  wire       i_timer_sel,
    input  wire       i_timer_data,
    input  wire       i_serial_sel,
    input  wire       i_serial_data,
    // pad
    output reg        o_out,
    output reg        o_oe_n
);

    // ****************************************************************
    // source choice
    // ****************************************************************
    reg next_out;
    reg next_oe_n;
    reg alt_data;
    reg alt_sel;
    reg drv_data;
    reg drv_od;
    reg drv_en;

    always @* begin
        alt_sel  = i_timer_sel | i_serial_sel;
        // timer wins over serial controller
        alt_data = i_timer_sel ? i_timer_data : i_serial_data;
        drv_en   = 1'b0;
        drv_od   = 1'b0;
        drv_data = 1'b0;
        case (i_field)
            `SPR_CFG_ALT_OUT: begin
                drv_en   = alt_sel;
                drv_data = alt_data;
            end
            `SPR_CFG_ALT_OD: begin
                drv_en   = alt_sel;
                drv_od   = 1'b1;
                drv_data = alt_data;
            end
            `SPR_CFG_GPIO_OUT: begin
                drv_en   = 1'b1;
                drv_data = i_gpio_data;
            end
            `SPR_CFG_GPIO_OD: begin
                drv_en   = 1'b1;
                drv_od   = 1'b1;
                drv_data = i_gpio_data;
            end
            default: begin
                drv_en   = 1'b0;
            end
        endcase
        next_out  = drv_od ? 1'b0 : drv_data;
        next_oe_n = ~drv_en | (drv_od & drv_data);
    end

    // ****************************************************************
    // pad flops
    // ****************************************************************
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_out  <= `SPR_RST_PIN_OUT;
            o_oe_n <= `SPR_RST_PIN_OE_N;
        end else begin
            o_out  <= next_out;
            o_oe_n <= next_oe_n;
        end
    end

endmodule

// ==== sim/spr_ext_peer.sv ====
`timescale 1ns/1ns

// ****************************************************************
// peripherals and board pull-ups on the four shared pads
// ****************************************************************
module spr_ext_peer (
    // device pad drivers
    input  wire logic [3:0] i_pin_out,
    input  wire logic [3:0] i_pin_oe_n,
    // peripheral drive control
    input  wire logic [3:0] i_ext_en,
    input  wire logic [3:0] i_ext_val,
    // resolved pad level
    output wire logic [3:0] o_pad
);
    // device wins while driving, else the peripheral, else the pull-up
    assign o_pad = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & i_ext_en & i_ext_val)
                 | (i_pin_oe_n & ~i_ext_en);
endmodule

// ==== sim/spr_pin_route_monitor.sv ====
`timescale 1ns/1ns

module spr_pin_route_monitor (
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic [7:0]  i_timer_remap_option,
    input wire logic [3:0]  i_timer_output_enable,
    input wire logic        i_gp_timer_channel_3_out,
    input wire logic [15:0] i_port_a_low_config,
    input wire logic [15:0] i_port_b_low_config,
    input wire logic [1:0]  i_serial1_mode_select,
    input wire logic [7:0]  i_serial1_spi_config,
    input wire logic [7:0]  i_serial1_uart_config,
    input wire logic        i_serial1_spi_clock_out,
    input wire logic [3:0]  i_pin_in,
    input wire logic [3:0]  o_pin_out,
    input wire logic [3:0]  o_pin_oe_n,
    input wire logic        o_gp_timer_channel_1_in,
    input wire logic        o_gp_timer_channel_3_in,
    input wire logic        o_gp_timer_channel_4_in,
    input wire logic        o_serial1_cts_n,
    input wire logic        o_serial1_slave_select_n
);
    wire       r4 = i_timer_remap_option[4];
    wire       r6 = i_timer_remap_option[6];
    wire       r7 = i_timer_remap_option[7];
    wire       t3 = i_timer_output_enable[2];
    wire [1:0] m1 = i_serial1_mode_select;
    wire       b3 = i_port_b_low_config[15:12] == 4'h9;
    wire       ch3_src  = r6 ? i_pin_in[2] : i_pin_in[1];
    wire       ch4_src  = r7 & i_pin_in[3];
    wire       cts_src  = m1 == 2'h1 && i_serial1_uart_config[5] && i_pin_in[2];
    wire       ssel_src = m1 != 2'h2 || i_serial1_spi_config[4] || i_pin_in[3];
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_b3_timer_out:
    assert property (!i_srst && r6 && t3 && b3 |=> !o_pin_oe_n[2] && o_pin_out[2] == $past(i_gp_timer_channel_3_out))
        else $error("timer ch3 not on port B pin 3");
    a_a1_timer_out:
    assert property (!i_srst && !r6 && t3 && i_port_a_low_config[7:4] == 4'h9
        |=> !o_pin_oe_n[1] && o_pin_out[1] == $past(i_gp_timer_channel_3_out)) else $error("timer ch3 not on pin A1");
    a_ch3_in_route:
    assert property (!i_srst |=> o_gp_timer_channel_3_in == $past(ch3_src))
        else $error("timer ch3 input wrong pin");
    a_ch4_in_route:
    assert property (!i_srst |=> o_gp_timer_channel_4_in == $past(ch4_src)) else $error("ch4 input wrong");
    a_ch1_in_gate:
    assert property ((!i_srst && r4) [*2] |-> !o_gp_timer_channel_1_in) else $error("ch1 input not gated");
    a_b3_spi_clock:
    assert property (!i_srst && m1 == 2'h2 && i_serial1_spi_config[4] && b3 && !(r6 && t3)
        |=> !o_pin_oe_n[2] && o_pin_out[2] == $past(i_serial1_spi_clock_out)) else $error("spi clock not driven");
    a_cts_sample:
    assert property (!i_srst |=> o_serial1_cts_n == $past(cts_src))
        else $error("cts sample wrong");
    a_ssel_route:
    assert property (!i_srst |=> o_serial1_slave_select_n == $past(ssel_src))
        else $error("slave select wrong");

    c_timer_b3: cover property (r6 && t3 && b3);
    c_uart_flow: cover property (m1 == 2'h1 && i_serial1_uart_config[5]);
    c_spi_slave: cover property (m1 == 2'h2 && !i_serial1_spi_config[4] && !i_pin_in[3]);
endmodule

bind spr_pin_route spr_pin_route_monitor spr_pin_route_monitor_inst (.*);

// ==== sim/tb_spr_pin_route.sv ====
`timescale 1ns/1ns

module tb_spr_pin_route;
    logic        i_clk;
    logic        i_srst;
    logic [7:0]  remap;
    logic [3:0]  toe;
    logic [2:0]  tmr;
    logic [15:0] pal, pbl, pbh;
    logic [1:0]  m1, m2;
    logic [7:0]  s1c, u1c, s2c;
    logic [4:0]  sio;
    logic [3:0]  ext_en, ext_val, gpo;
    wire  [3:0]  pad, pout, poe, gin;
    wire  [8:0]  ins;
    int          err_count, samples_checked;

    spr_pin_route spr_pin_route_inst (.i_clk(i_clk), .i_srst(i_srst), .i_timer_remap_option(remap),
        .i_timer_output_enable(toe), .i_gp_timer_channel_1_out(tmr[0]), .i_gp_timer_channel_3_out(tmr[1]),
        .i_gp_timer_channel_4_out(tmr[2]), .i_port_a_low_config(pal), .i_port_b_low_config(pbl),
        .i_port_b_high_config(pbh), .i_gpio_out(gpo), .i_serial1_mode_select(m1), .i_serial1_spi_config(s1c),
        .i_serial1_uart_config(u1c), .i_serial1_spi_clock_out(sio[0]), .i_serial1_rts_n(sio[1]),
        .i_serial2_mode_select(m2), .i_serial2_spi_config(s2c), .i_serial2_master_out(sio[2]),
        .i_serial2_slave_out(sio[3]), .i_serial2_i2c_data_out(sio[4]), .i_pin_in(pad), .o_pin_out(pout),
        .o_pin_oe_n(poe), .o_gpio_in(gin), .o_gp_timer_channel_1_in(ins[8]), .o_gp_timer_channel_3_in(ins[7]),
        .o_gp_timer_channel_4_in(ins[6]), .o_serial1_spi_clock_in(ins[5]), .o_serial1_cts_n(ins[4]),
        .o_serial1_slave_select_n(ins[3]), .o_serial2_slave_in(ins[2]), .o_serial2_master_in(ins[1]),
        .o_serial2_i2c_data_in(ins[0]));
    spr_ext_peer spr_ext_peer_inst (.i_pin_out(pout), .i_pin_oe_n(poe), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_pad(pad));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic cmp(input logic [8:0] got, input logic [8:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // pad data is compared only where the pad is expected to drive
    task automatic check(input logic [3:0] eout, input logic [3:0] eoe, input logic [8:0] ein);
        repeat (2) @(posedge i_clk);
        #1;
        cmp({5'h00, pout & ~eoe}, {5'h00, eout}, "pad data");
        cmp({5'h00, poe}, {5'h00, eoe}, "pad enable");
        cmp(ins, ein, "routed inputs");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        err_count = 0;
        samples_checked = 0;
        {i_srst, remap, toe, tmr, pal, pbl, pbh, m1, m2} = {1'b1, 8'h00, 4'h0, 3'h0, 16'h0000, 16'h9000,
            16'h0009, 2'h0, 2'h0};
        {s1c, u1c, s2c, sio, ext_en, ext_val, gpo} = {8'h00, 8'h00, 8'h00, 5'h00, 4'h0, 4'h0, 4'h0};
        repeat (4) @(posedge i_clk);
        #1;
        cmp({5'h00, poe}, 9'h00F, "reset enable");
        cmp(ins, 9'b000001001, "reset inputs");
        cmp({5'h00, gin}, 9'h000, "reset gpio readback");
        @(posedge i_clk);
        i_srst <= 1'b0;
        {remap, toe, tmr, pal, m1, s1c, m2, s2c} <= {8'hD0, 4'hF, 3'b011, 16'h0099, 2'h2, 8'h10, 2'h2, 8'h10};
        {ext_en, ext_val} <= {4'h2, 4'h2};
        check(4'b0100, 4'b0010, 9'b010001011);
        $display("test remapped timer done");
        @(posedge i_clk);
        {remap, tmr, m1, u1c, m2, sio} <= {8'h00, 3'b001, 2'h1, 8'h20, 2'h3, 5'b10010};
        {ext_en, ext_val} <= {4'h4, 4'h4};
        check(4'b1001, 4'b0100, 9'b100011000);
        $display("test unremapped timer done");
        @(posedge i_clk);
        {toe, tmr, m1, s1c, pal, sio} <= {4'h0, 3'b111, 2'h2, 8'h00, 16'h00D9, 5'b11111};
        {ext_en, ext_val} <= {4'hC, 4'h4};
        check(4'h0, 4'hF, 9'b110100001);
        @(posedge i_clk);
        sio <= 5'b01111;
        check(4'h0, 4'b1101, 9'b100100000);
        $display("test serial slave and i2c done");
        @(posedge i_clk);
        {s1c, m2, s2c, pal, sio} <= {8'h10, 2'h2, 8'h00, 16'h0090, 5'b01001};
        {ext_en, ext_val} <= {4'h1, 4'h1};
        check(4'b0110, 4'b1001, 9'b110001101);
        $display("test spi clock and slave data done");
        @(posedge i_clk);
        {pal, pbl, pbh, gpo, ext_en} <= {16'h0051, 16'h5000, 16'h0001, 4'b1010, 4'h0};
        check(4'b1000, 4'b0010, 9'b010001001);
        cmp({5'h00, gin}, 9'h00A, "gpio readback");
        $display("test gpio pads done");
        complete_run();
    end
endmodule
